// *** bench/usd_far_model.sv ***
// Far side: character source and byte sink
module usd_far_model (
   input wire logic clk_i,
   input wire logic stall_i,
   input wire logic tx_valid_i,
   input wire logic [7:0] tx_data_i,
   output logic tx_ready_o,
   output logic uart_valid_o,
   output logic [7:0] uart_data_o,
   output logic ir_valid_o,
   output logic [7:0] ir_data_o
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [7:0] last_tx = 8'h00;
   int tx_count = 0;
   initial begin
      uart_valid_o = 1'b0;
      ir_valid_o = 1'b0;
      uart_data_o = 8'h00;
      ir_data_o = 8'h00;
   end
   assign tx_ready_o = !stall_i;
   always @(posedge clk_i) begin
      if (tx_valid_i && tx_ready_o) begin
         last_tx <= tx_data_i;
         tx_count <= tx_count + 1;
      end
   end
   // One-cycle pulse; idle data lines are scrambled
   task automatic send(input logic [7:0] b, input logic ir);
      @(posedge clk_i);
      if (ir) begin
         ir_valid_o <= 1'b1;
         ir_data_o <= b;
      end else begin
         uart_valid_o <= 1'b1;
         uart_data_o <= b;
      end
      @(posedge clk_i);
      uart_valid_o <= 1'b0;
      ir_valid_o <= 1'b0;
      uart_data_o <= ~uart_data_o;
      ir_data_o <= ~ir_data_o;
   endtask
endmodule

// *** bench/usd_shadow_data_port_properties.sv ***
// Pin-level checks on the shadow data port
module usd_shadow_data_port_properties (
   input wire logic clk_i,
   input wire logic srst_i,
   input wire logic hsel_i,
   input wire logic [31:0] haddr_i,
   input wire logic [1:0] htrans_i,
   input wire logic hwrite_i,
   input wire logic hready_i,
   input wire logic hreadyout_o,
   input wire logic hresp_o,
   input wire logic [31:0] hrdata_o,
   input wire logic rx_uart_valid_i,
   input wire logic tx_valid_o,
   input wire logic [7:0] tx_data_o,
   input wire logic tx_ready_i,
   input wire logic tx_ir_mode_o,
   input wire logic rx_data_ready_o,
   input wire logic tx_holding_empty_o,
   input wire logic overrun_o,
   input wire logic fifo_enable_o
);
   timeunit 1ns;
   timeprecision 1ps;
   logic rd_dp_r;
   logic wr_dp_r;
   logic wr_sh_r;
   logic addr_ph;
   assign addr_ph = hsel_i && htrans_i[1] && hready_i;
   always_ff @(posedge clk_i) begin
      rd_dp_r <= !srst_i && addr_ph && !hwrite_i;
      wr_dp_r <= !srst_i && addr_ph && hwrite_i;
      wr_sh_r <= !srst_i && addr_ph && hwrite_i && haddr_i >= usd_pkg::SHADOW_BASE_ADDR
         && haddr_i <= usd_pkg::SHADOW_LAST_ADDR && haddr_i[1:0] == 2'h0;
   end
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (srst_i);
   a_bus_always_okay: assert property (hreadyout_o && hresp_o == 1'b0)
      else $error("bus not ready or not OKAY");
   a_rdata_reserved_zero: assert property (hrdata_o[31:8] == 24'h0)
      else $error("reserved read bits set");
   a_rdata_idle_zero: assert property (!rd_dp_r |-> hrdata_o == 32'h0)
      else $error("read data outside data phase");
   a_rx_sets_ready: assert property ((rx_uart_valid_i && !tx_ir_mode_o && !addr_ph && !wr_dp_r) |=> rx_data_ready_o)
      else $error("arrival did not raise data ready");
   a_ready_holds: assert property ((rx_data_ready_o && !addr_ph && !wr_dp_r) |=> rx_data_ready_o)
      else $error("data ready dropped without a read");
   a_overwrite_overrun: assert property ((!fifo_enable_o && rx_data_ready_o && rx_uart_valid_i && !tx_ir_mode_o
      && !addr_ph && !wr_dp_r) |=> overrun_o)
      else $error("overwrite without overrun");
   a_busy_not_empty: assert property (tx_valid_o |-> !tx_holding_empty_o)
      else $error("holding empty while byte pending");
   a_write_clears_empty: assert property ((wr_sh_r && !fifo_enable_o) |=> !tx_holding_empty_o)
      else $error("shadow write left holding empty set");
   a_pending_held: assert property ((tx_valid_o && !tx_ready_i && !wr_dp_r) |=> tx_valid_o && $stable(tx_data_o))
      else $error("pending byte changed without write");
   c_overrun: cover property (overrun_o);
   c_fifo_read: cover property (fifo_enable_o && rd_dp_r);
   c_tx_stall: cover property (tx_valid_o && !tx_ready_i ##1 tx_valid_o && tx_ready_i);
endmodule

bind usd_shadow_data_port usd_shadow_data_port_properties i_props (.clk_i(clk_i), .srst_i(srst_i),
   .hsel_i(hsel_i), .haddr_i(haddr_i), .htrans_i(htrans_i), .hwrite_i(hwrite_i), .hready_i(hready_i),
   .hreadyout_o(hreadyout_o),
   .hresp_o(hresp_o), .hrdata_o(hrdata_o), .rx_uart_valid_i(rx_uart_valid_i), .tx_valid_o(tx_valid_o),
   .tx_data_o(tx_data_o), .tx_ready_i(tx_ready_i), .tx_ir_mode_o(tx_ir_mode_o), .rx_data_ready_o(rx_data_ready_o),
   .tx_holding_empty_o(tx_holding_empty_o), .overrun_o(overrun_o), .fifo_enable_o(fifo_enable_o));

// *** bench/usd_shadow_data_port_tb.sv ***
// Self-checking bench for the shadow data port
module usd_shadow_data_port_tb;
   timeunit 1ns;
   timeprecision 1ps;
   localparam logic [31:0] SH = usd_pkg::SHADOW_BASE_ADDR;
   localparam logic [31:0] ST = usd_pkg::STAT_ADDR;
   localparam logic [31:0] CT = usd_pkg::CTRL_ADDR;
   logic clk_i = 1'b0;
   logic srst_i = 1'b1;
   logic hsel_i = 1'b0;
   logic [31:0] haddr_i = 32'h0;
   logic [1:0] htrans_i = 2'h0;
   logic hwrite_i = 1'b0;
   logic [31:0] hwdata_i = 32'h0;
   logic stall = 1'b0;
   logic hreadyout_o, hresp_o, u_v, i_v, tx_v, tx_rdy, ir_m, rdy, empty, ovr, fen;
   logic [31:0] hrdata_o;
   logic [7:0] u_d, i_d, tx_d;
   int err_count = 0;
   int tests_run = 0;
   int base;

   usd_shadow_data_port i_dut (.clk_i(clk_i), .srst_i(srst_i), .hsel_i(hsel_i), .haddr_i(haddr_i),
      .htrans_i(htrans_i), .hwrite_i(hwrite_i), .hsize_i(3'h2), .hwdata_i(hwdata_i), .hready_i(hreadyout_o),
      .hreadyout_o(hreadyout_o), .hresp_o(hresp_o), .hrdata_o(hrdata_o), .rx_uart_valid_i(u_v),
      .rx_uart_data_i(u_d), .rx_ir_valid_i(i_v), .rx_ir_data_i(i_d), .tx_valid_o(tx_v), .tx_data_o(tx_d),
      .tx_ready_i(tx_rdy), .tx_ir_mode_o(ir_m), .rx_data_ready_o(rdy), .tx_holding_empty_o(empty),
      .overrun_o(ovr), .fifo_enable_o(fen));
   usd_far_model i_far (.clk_i(clk_i), .stall_i(stall), .tx_valid_i(tx_v), .tx_data_i(tx_d),
      .tx_ready_o(tx_rdy), .uart_valid_o(u_v), .uart_data_o(u_d), .ir_valid_o(i_v), .ir_data_o(i_d));

   initial begin
      forever #12.5 clk_i = ~clk_i;
   end

   task automatic give_verdict();
      $display("mismatches %0d of %0d checks", err_count, tests_run);
      if (err_count == 0 && tests_run > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp) begin
         err_count++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d, output logic [31:0] q);
      int n;
      n = 0;
      hsel_i <= 1'b1;
      htrans_i <= 2'h2;
      haddr_i <= a;
      hwrite_i <= w;
      do @(posedge clk_i); while (hreadyout_o !== 1'b1 && ++n < 50);
      hsel_i <= 1'b0;
      htrans_i <= 2'h0;
      hwdata_i <= d;
      do @(posedge clk_i); while (hreadyout_o !== 1'b1 && ++n < 50);
      q = hrdata_o;
      if (n >= 50) begin
         err_count++;
         give_verdict();
      end
   endtask

   task automatic rd(input logic [31:0] a, input logic [31:0] e);
      logic [31:0] q;
      bus(1'b0, a, 32'h0, q);
      chk(q, e);
   endtask

   task automatic wr(input logic [31:0] a, input logic [31:0] d);
      logic [31:0] q;
      bus(1'b1, a, d, q);
   endtask

   task automatic wait_tx(input int n);
      for (int i = 0; i < 200 && i_far.tx_count < n; i++) @(posedge clk_i);
      if (i_far.tx_count < n) begin
         err_count++;
         give_verdict();
      end
   endtask

   initial begin
      repeat (5) @(posedge clk_i);
      srst_i <= 1'b0;
      @(posedge clk_i);
      rd(ST, 32'h20);
      rd(SH + 32'h28, 32'h0);
      for (int k = 0; k < 16; k++) begin
         i_far.send(8'(8'h30 + k), 1'b0);
         rd(SH + 32'(4 * k), {24'h0, 8'(8'h30 + k)});
      end
      chk({31'h0, hresp_o}, 32'h0);
      i_far.send(8'h11, 1'b0);
      i_far.send(8'h22, 1'b0);
      @(posedge clk_i);
      chk({30'h0, ovr, rdy}, 32'h3);
      rd(ST, 32'h23);
      rd(SH, 32'h22);
      rd(ST, 32'h20);
      rd(32'h5000_1178, 32'h0);
      wr(CT, 32'h2);
      @(posedge clk_i);
      chk({31'h0, ir_m}, 32'h1);
      i_far.send(8'h77, 1'b0);
      i_far.send(8'h5A, 1'b1);
      rd(SH, 32'h5A);
      rd(ST, 32'h20);
      wr(CT, 32'h0);
      stall <= 1'b1;
      chk({31'h0, empty}, 32'h1);
      wr(SH, 32'h41);
      wr(SH + 32'h4, 32'h42);
      chk({31'h0, empty}, 32'h0);
      base = i_far.tx_count;
      stall <= 1'b0;
      wait_tx(base + 1);
      repeat (3) @(posedge clk_i);
      chk(32'(i_far.tx_count - base), 32'h1);
      chk({24'h0, i_far.last_tx}, 32'h42);
      chk({31'h0, empty}, 32'h1);
      wr(CT, 32'h1);
      for (int k = 0; k < 33; k++) i_far.send(8'(k), 1'b0);
      rd(ST, 32'h2B);
      chk({31'h0, fen}, 32'h1);
      for (int k = 0; k < 32; k++) rd(SH, 32'(k));
      rd(ST, 32'h20);
      stall <= 1'b1;
      for (int k = 0; k < 17; k++) wr(SH, 32'h80 + 32'(k));
      rd(ST, 32'h04);
      base = i_far.tx_count;
      stall <= 1'b0;
      wait_tx(base + 16);
      repeat (3) @(posedge clk_i);
      chk(32'(i_far.tx_count - base), 32'h10);
      chk({24'h0, i_far.last_tx}, 32'h8F);
      give_verdict();
   end
endmodule

// *** rtl/usd_fifo.sv ***
// Synchronous FIFO with valid/ready on both sides and a flush
module usd_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 32
) (
   input wire logic clk_i,
   input wire logic srst_i,
   input wire logic flush_i,
   input wire logic in_valid_i,
   output logic in_ready_o,
   input wire logic [WIDTH-1:0] in_data_i,
   output logic out_valid_o,
   input wire logic out_ready_i,
   output logic [WIDTH-1:0] out_data_o,
   output logic full_o,
   output logic empty_o
);
   localparam int AW = $clog2(DEPTH);

   logic [WIDTH-1:0] mem_r [DEPTH];
   logic [AW:0] wr_ptr_r;
   logic [AW:0] wr_ptr_nxt;
   logic [AW:0] rd_ptr_r;
   logic [AW:0] rd_ptr_nxt;
   logic push;
   logic pop;

   // Pointers carry one wrap bit so full and empty stay distinct
   assign full_o = (wr_ptr_r[AW] != rd_ptr_r[AW]) && (wr_ptr_r[AW-1:0] == rd_ptr_r[AW-1:0]);
   assign empty_o = (wr_ptr_r == rd_ptr_r);
   assign in_ready_o = !full_o;
   assign out_valid_o = !empty_o;
   assign out_data_o = mem_r[rd_ptr_r[AW-1:0]];
   assign push = in_valid_i && !full_o;
   assign pop = out_ready_i && !empty_o;

   always_comb begin
      wr_ptr_nxt = wr_ptr_r;
      rd_ptr_nxt = rd_ptr_r;
      if (flush_i) begin
         wr_ptr_nxt = '0;
         rd_ptr_nxt = '0;
      end else begin
         if (push) begin
            wr_ptr_nxt = wr_ptr_r + (AW+1)'(1);
         end
         if (pop) begin
            rd_ptr_nxt = rd_ptr_r + (AW+1)'(1);
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         wr_ptr_r <= '0;
         rd_ptr_r <= '0;
      end else begin
         wr_ptr_r <= wr_ptr_nxt;
         rd_ptr_r <= rd_ptr_nxt;
      end
   end

   always_ff @(posedge clk_i) begin
      if (push && !flush_i) begin
         mem_r[wr_ptr_r[AW-1:0]] <= in_data_i;
      end
   end
endmodule

// *** rtl/usd_pkg.sv ***
// Constants for the UART shadow data port: address map, fields, depths, reset values
package usd_pkg;
   localparam int DATA_W = 8;
   localparam int BUS_W = 32;
   localparam int RX_FIFO_DEPTH = 32;
   localparam int TX_FIFO_DEPTH = 16;

   // Sixteen aliased shadow data words, word 10 sits at the printed address
   localparam logic [31:0] SHADOW_WORD10_ADDR = 32'h5000_1158;
   localparam logic [31:0] SHADOW_INDEX10 = 32'h0000_000A;
   localparam logic [31:0] SHADOW_BASE_ADDR = SHADOW_WORD10_ADDR - (SHADOW_INDEX10 << 2);
   localparam logic [31:0] SHADOW_LAST_ADDR = SHADOW_BASE_ADDR + 32'h0000_003C;
   localparam logic [31:0] CTRL_ADDR = 32'h5000_1170;
   localparam logic [31:0] STAT_ADDR = 32'h5000_1174;
   localparam logic [1:0] WORD_ALIGN = 2'h0;

   // Data-phase target codes
   localparam logic [1:0] SEL_NONE = 2'h0;
   localparam logic [1:0] SEL_SHADOW = 2'h1;
   localparam logic [1:0] SEL_CTRL = 2'h2;
   localparam logic [1:0] SEL_STAT = 2'h3;

   // Control register fields
   localparam int CTRL_FIFO_EN_BIT = 0;
   localparam int CTRL_IR_MODE_BIT = 1;
   // Status register fields
   localparam int STAT_DATA_READY_BIT = 0;
   localparam int STAT_OVERRUN_BIT = 1;
   localparam int STAT_TX_FULL_BIT = 2;
   localparam int STAT_RX_FULL_BIT = 3;
   localparam int STAT_TX_EMPTY_BIT = 5;

   // AHB transfer type and response
   localparam int HTRANS_ACTIVE_BIT = 1;
   localparam logic HRESP_OKAY = 1'b0;

   // Reset values
   localparam logic [BUS_W-1:0] RDATA_RST = 32'h0000_0000;
   localparam logic [DATA_W-1:0] BYTE_RST = 8'h00;
endpackage

// *** rtl/usd_shadow_data_port.sv ***
// UART shadow receive/transmit data port behind an AHB-Lite slave
module usd_shadow_data_port (
   input wire logic clk_i,
   input wire logic srst_i,
   // AHB-Lite slave
   input wire logic hsel_i,
   input wire logic [31:0] haddr_i,
   input wire logic [1:0] htrans_i,
   input wire logic hwrite_i,
   input wire logic [2:0] hsize_i,
   input wire logic [31:0] hwdata_i,
   input wire logic hready_i,
   output logic hreadyout_o,
   output logic hresp_o,
   output logic [31:0] hrdata_o,
   // Received characters from the UART and infrared deserialisers
   input wire logic rx_uart_valid_i,
   input wire logic [7:0] rx_uart_data_i,
   input wire logic rx_ir_valid_i,
   input wire logic [7:0] rx_ir_data_i,
   // Characters to the transmit serialiser
   output logic tx_valid_o,
   output logic [7:0] tx_data_o,
   input wire logic tx_ready_i,
   output logic tx_ir_mode_o,
   // Status flags to the rest of the UART
   output logic rx_data_ready_o,
   output logic tx_holding_empty_o,
   output logic overrun_o,
   output logic fifo_enable_o
);
   localparam int DW = usd_pkg::DATA_W;

   // Bus data phase state
   logic dp_valid_r;
   logic dp_valid_nxt;
   logic dp_write_r;
   logic dp_write_nxt;
   logic [1:0] dp_sel_r;
   logic [1:0] dp_sel_nxt;
   logic [31:0] hrdata_r;
   logic [31:0] hrdata_nxt;

   // Control and line state
   logic fifo_en_r;
   logic fifo_en_nxt;
   logic ir_mode_r;
   logic ir_mode_nxt;
   logic overrun_r;
   logic overrun_nxt;
   logic rx_ready_r;
   logic rx_ready_nxt;
   logic [DW-1:0] rx_buffer_r;
   logic [DW-1:0] rx_buffer_nxt;
   logic tx_hold_empty_r;
   logic tx_hold_empty_nxt;
   logic [DW-1:0] tx_holding_r;
   logic [DW-1:0] tx_holding_nxt;

   // Decode and strobes
   logic take;
   logic [1:0] sel;
   logic rd_shadow;
   logic rd_stat;
   logic wr_shadow;
   logic wr_ctrl;
   logic flush;
   logic rx_in_valid;
   logic [DW-1:0] rx_in_data;
   logic [DW-1:0] rx_head;
   logic data_ready;
   logic tx_empty;

   // FIFO ports
   logic rxf_in_valid;
   logic rxf_in_ready;
   logic rxf_out_valid;
   logic rxf_out_ready;
   logic [DW-1:0] rxf_out_data;
   logic rxf_full;
   logic txf_in_valid;
   logic txf_out_valid;
   logic txf_out_ready;
   logic [DW-1:0] txf_out_data;
   logic txf_full;
   logic txf_empty;

   // Address phase accepted when selected, active and bus ready
   assign take = hsel_i && htrans_i[usd_pkg::HTRANS_ACTIVE_BIT] && hready_i;

   always_comb begin
      sel = usd_pkg::SEL_NONE;
      if (haddr_i[1:0] == usd_pkg::WORD_ALIGN) begin
         if (haddr_i >= usd_pkg::SHADOW_BASE_ADDR && haddr_i <= usd_pkg::SHADOW_LAST_ADDR) begin
            sel = usd_pkg::SEL_SHADOW;
         end else if (haddr_i == usd_pkg::CTRL_ADDR) begin
            sel = usd_pkg::SEL_CTRL;
         end else if (haddr_i == usd_pkg::STAT_ADDR) begin
            sel = usd_pkg::SEL_STAT;
         end
      end
   end

   assign rd_shadow = take && !hwrite_i && (sel == usd_pkg::SEL_SHADOW);
   assign rd_stat = take && !hwrite_i && (sel == usd_pkg::SEL_STAT);
   assign wr_shadow = dp_valid_r && dp_write_r && (dp_sel_r == usd_pkg::SEL_SHADOW);
   assign wr_ctrl = dp_valid_r && dp_write_r && (dp_sel_r == usd_pkg::SEL_CTRL);

   // Changing the FIFO enable empties both FIFOs
   assign flush = wr_ctrl && (hwdata_i[usd_pkg::CTRL_FIFO_EN_BIT] != fifo_en_r);

   // Receive source follows the infrared mode bit
   assign rx_in_valid = ir_mode_r ? rx_ir_valid_i : rx_uart_valid_i;
   assign rx_in_data = ir_mode_r ? rx_ir_data_i : rx_uart_data_i;

   // Reading an empty FIFO returns the stale head byte
   assign rx_head = fifo_en_r ? rxf_out_data : rx_buffer_r;
   assign data_ready = fifo_en_r ? rxf_out_valid : rx_ready_r;
   assign tx_empty = fifo_en_r ? txf_empty : tx_hold_empty_r;

   // Receive FIFO, filled by the deserialiser and drained by shadow reads
   assign rxf_in_valid = fifo_en_r && rx_in_valid && !flush;
   assign rxf_out_ready = fifo_en_r && rd_shadow;

   usd_fifo #(
      .WIDTH(usd_pkg::DATA_W),
      .DEPTH(usd_pkg::RX_FIFO_DEPTH)
   ) u_rx_fifo (
      .clk_i(clk_i),
      .srst_i(srst_i),
      .flush_i(flush),
      .in_valid_i(rxf_in_valid),
      .in_ready_o(rxf_in_ready),
      .in_data_i(rx_in_data),
      .out_valid_o(rxf_out_valid),
      .out_ready_i(rxf_out_ready),
      .out_data_o(rxf_out_data),
      .full_o(rxf_full),
      .empty_o()
   );

   // Transmit FIFO; a full FIFO refuses the byte and it is lost
   assign txf_in_valid = fifo_en_r && wr_shadow && !flush;
   assign txf_out_ready = fifo_en_r && tx_ready_i;

   usd_fifo #(
      .WIDTH(usd_pkg::DATA_W),
      .DEPTH(usd_pkg::TX_FIFO_DEPTH)
   ) u_tx_fifo (
      .clk_i(clk_i),
      .srst_i(srst_i),
      .flush_i(flush),
      .in_valid_i(txf_in_valid),
      .in_ready_o(),
      .in_data_i(hwdata_i[DW-1:0]),
      .out_valid_o(txf_out_valid),
      .out_ready_i(txf_out_ready),
      .out_data_o(txf_out_data),
      .full_o(txf_full),
      .empty_o(txf_empty)
   );

   // Bus phase tracking and read data
   always_comb begin
      dp_valid_nxt = take;
      dp_write_nxt = take && hwrite_i;
      dp_sel_nxt = take ? sel : usd_pkg::SEL_NONE;
      hrdata_nxt = usd_pkg::RDATA_RST;
      if (take && !hwrite_i) begin
         case (sel)
            usd_pkg::SEL_SHADOW: begin
               hrdata_nxt[DW-1:0] = rx_head;
            end
            usd_pkg::SEL_CTRL: begin
               hrdata_nxt[usd_pkg::CTRL_FIFO_EN_BIT] = fifo_en_r;
               hrdata_nxt[usd_pkg::CTRL_IR_MODE_BIT] = ir_mode_r;
            end
            usd_pkg::SEL_STAT: begin
               hrdata_nxt[usd_pkg::STAT_DATA_READY_BIT] = data_ready;
               hrdata_nxt[usd_pkg::STAT_OVERRUN_BIT] = overrun_r;
               hrdata_nxt[usd_pkg::STAT_TX_FULL_BIT] = fifo_en_r && txf_full;
               hrdata_nxt[usd_pkg::STAT_RX_FULL_BIT] = fifo_en_r && rxf_full;
               hrdata_nxt[usd_pkg::STAT_TX_EMPTY_BIT] = tx_empty;
            end
            default: begin
               hrdata_nxt = usd_pkg::RDATA_RST;
            end
         endcase
      end
   end

   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         dp_valid_r <= 1'b0;
         dp_write_r <= 1'b0;
         dp_sel_r <= usd_pkg::SEL_NONE;
         hrdata_r <= usd_pkg::RDATA_RST;
      end else begin
         dp_valid_r <= dp_valid_nxt;
         dp_write_r <= dp_write_nxt;
         dp_sel_r <= dp_sel_nxt;
         hrdata_r <= hrdata_nxt;
      end
   end

   // Control, receive buffer, transmit holding and overrun
   always_comb begin
      fifo_en_nxt = fifo_en_r;
      ir_mode_nxt = ir_mode_r;
      overrun_nxt = overrun_r;
      rx_ready_nxt = rx_ready_r;
      rx_buffer_nxt = rx_buffer_r;
      tx_hold_empty_nxt = tx_hold_empty_r;
      tx_holding_nxt = tx_holding_r;

      if (wr_ctrl) begin
         fifo_en_nxt = hwdata_i[usd_pkg::CTRL_FIFO_EN_BIT];
         ir_mode_nxt = hwdata_i[usd_pkg::CTRL_IR_MODE_BIT];
      end

      // Status read clears overrun; a new overrun below wins
      if (rd_stat) begin
         overrun_nxt = 1'b0;
      end

      if (!fifo_en_r) begin
         if (rd_shadow) begin
            rx_ready_nxt = 1'b0;
         end
         if (rx_in_valid) begin
            if (rx_ready_r && !rd_shadow) begin
               overrun_nxt = 1'b1;
            end
            rx_buffer_nxt = rx_in_data;
            rx_ready_nxt = 1'b1;
         end
         if (tx_ready_i && !tx_hold_empty_r) begin
            tx_hold_empty_nxt = 1'b1;
         end
         if (wr_shadow) begin
            tx_holding_nxt = hwdata_i[DW-1:0];
            tx_hold_empty_nxt = 1'b0;
         end
      end else if (rxf_in_valid && !rxf_in_ready) begin
         overrun_nxt = 1'b1;
      end

      // Leaving or entering FIFO mode starts from empty buffers
      if (flush) begin
         rx_ready_nxt = 1'b0;
         tx_hold_empty_nxt = 1'b1;
      end
   end

   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         fifo_en_r <= 1'b0;
         ir_mode_r <= 1'b0;
         overrun_r <= 1'b0;
         rx_ready_r <= 1'b0;
         rx_buffer_r <= usd_pkg::BYTE_RST;
         tx_hold_empty_r <= 1'b1;
         tx_holding_r <= usd_pkg::BYTE_RST;
      end else begin
         fifo_en_r <= fifo_en_nxt;
         ir_mode_r <= ir_mode_nxt;
         overrun_r <= overrun_nxt;
         rx_ready_r <= rx_ready_nxt;
         rx_buffer_r <= rx_buffer_nxt;
         tx_hold_empty_r <= tx_hold_empty_nxt;
         tx_holding_r <= tx_holding_nxt;
      end
   end

   // Zero wait states, always OKAY
   assign hreadyout_o = 1'b1;
   assign hresp_o = usd_pkg::HRESP_OKAY;
   assign hrdata_o = hrdata_r;

   assign tx_valid_o = fifo_en_r ? txf_out_valid : !tx_hold_empty_r;
   assign tx_data_o = fifo_en_r ? txf_out_data : tx_holding_r;
   assign tx_ir_mode_o = ir_mode_r;
   assign rx_data_ready_o = data_ready;
   assign tx_holding_empty_o = tx_empty;
   assign overrun_o = overrun_r;
   assign fifo_enable_o = fifo_en_r;
endmodule
